// ==== inc/tgf_pkg.sv ====
// package: constants and carrier types for the trace and guard fault logic
package tgf_pkg;

  // ----------------------------------------------------------------------
  // apb register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_TRACE_CTRL   = 8'h00; // trace_control_register
  localparam logic [7:0] ADDR_PROC_CTRL    = 8'h04; // process_control_register
  localparam logic [7:0] ADDR_FAULT_STATUS = 8'h08; // last fault type/subtype
  localparam logic [7:0] ADDR_INDICATOR    = 8'h0c; // indicator word
  localparam logic [7:0] ADDR_EVENT_COUNT  = 8'h10; // raised fault count

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int          PC_TE_BIT        = 0;     // trace enable bit
  localparam logic [7:0]  TC_MODE_RESET    = 8'h00; // all modes off
  localparam logic        PC_TE_RESET      = 1'b0;
  localparam int          IND_PROT_LSB     = 0;     // protect pair bits 1:0
  localparam int          IND_DET_LSB      = 16;    // detect pair bits 21:16
  localparam int          PREFETCH_WORDS   = 16;    // prefetch reach in words

  // ----------------------------------------------------------------------
  // fault codes
  // ----------------------------------------------------------------------
  localparam logic [3:0] FT_TRACE      = 4'h1;
  localparam logic [3:0] FT_PROTECTION = 4'h7;
  localparam logic [7:0] FS_LENGTH     = 8'h02;
  localparam logic [7:0] FS_BAD_ACCESS = 8'h01;

  // trace subtype bit positions
  localparam int SB_INSTR  = 1;
  localparam int SB_BRANCH = 2;
  localparam int SB_CALL   = 3;
  localparam int SB_RETURN = 4;
  localparam int SB_PRERET = 5;
  localparam int SB_SUPER  = 6;
  localparam int SB_MARK   = 7;

  // return-status types that count as supervisor returns
  localparam logic [2:0] RS_SUPER_A = 3'h2;
  localparam logic [2:0] RS_SUPER_B = 3'h3;

  // ----------------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------------
  // completion report of one instruction from the pipeline
  typedef struct packed {
    logic       valid;        // instruction retires this cycle
    logic       is_branch;    // plain branch
    logic       taken;        // branch taken
    logic       is_bal;       // branch-and-link
    logic       is_call;      // call instruction
    logic       is_calls_sup; // system call to a supervisor procedure
    logic       fault_call;   // implicit fault call
    logic       is_ret;       // return instruction
    logic [2:0] ret_status;   // return-status type of previous_frame_link
    logic       is_mark;      // mark or fmark
    logic       bkpt_hit;     // instruction or data breakpoint match
  } tgf_retire_type;

  // guarded memory check outcome for the retiring instruction
  typedef struct packed {
    logic       length_fault; // segment-length fault
    logic [1:0] prot_hit;     // protect pairs violated
    logic [5:0] det_hit;      // detect pairs violated
  } tgf_guard_type;

  // fault request to the dispatch logic
  typedef struct packed {
    logic       valid;
    logic [3:0] ftype;
    logic [7:0] subtype;
    logic [31:0] indicator;
  } tgf_fault_type;

endpackage

// ==== testbench/tb_tgf_fault_unit.sv ====
// testbench: fault unit against a behavioural trace and guard model
`timescale 1ns/10ps
`default_nettype none
module tb_tgf_fault_unit;
  // ---------------------------------------------------------------
  // signals; ce is tied high, freezing is not exercised
  // ---------------------------------------------------------------
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, go = 1'b0, pfl = 1'b0;
  logic hret = 1'b0, hfp = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic te = 1'b0, se, rdy, serr, cm, cr, spf, hr, lk;
  logic [7:0] pa = '0, mode = '0, pend = '0;
  logic [31:0] pwd = '0, rd, prd, rs = 32'h62;
  tgf_pkg::tgf_retire_type cmd = '0, ret;
  tgf_pkg::tgf_guard_type gcmd = '0, grd;
  tgf_pkg::tgf_fault_type flt;
  int err_total = 0, checked = 0;
  always #4 clk = ~clk;
  tgf_fault_unit tgf_fault_unit_i (.CLOCK(clk), .RST(rst), .CE(ce),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd),
    .PRDATA(prd), .PREADY(rdy), .PSLVERR(serr), .RETIRE(ret), .GUARD(grd),
    .PRERET_FLAG(pfl), .HANDLER_RETURN(hret), .HANDLER_FETCH_PROT(hfp),
    .COMMIT_MEM(cm), .COMMIT_REG(cr), .SET_PRERET_FLAG(spf),
    .HOLD_RETURN(hr), .FAULT(flt), .LOCKUP(lk));
  tgf_pipe_model tgf_pipe_model_i (.clk(clk), .rst(rst), .go(go),
    .cmd(cmd), .gcmd(gcmd), .retire(ret), .guard(grd));
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // apb transfer; read data and error taken at the pready edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr  <= w;
    pa   <= a;
    pwd  <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    rd = prd;
    se = serr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  task automatic setm(input logic [7:0] m, input logic t);
    mode = m;
    te   = t;
    apb(1'b1, tgf_pkg::ADDR_TRACE_CTRL, {24'h0, m});
    apb(1'b1, tgf_pkg::ADDR_PROC_CTRL, {31'h0, t});
  endtask
  // model: trace subtype bits expected for one retire
  function automatic logic [7:0] sub(input tgf_pkg::tgf_retire_type r);
    sub = '0;
    sub[1] = mode[1];
    sub[2] = mode[2] & r.is_branch & r.taken & ~r.is_bal & ~r.is_call;
    sub[3] = mode[3] & (r.is_call | r.is_bal | r.fault_call);
    sub[4] = mode[4] & r.is_ret;
    sub[6] = mode[6] & (r.is_calls_sup | r.is_ret & r.ret_status[2:1] == 2'h1);
    sub[7] = mode[7] & (r.is_mark | r.bkpt_hit);
  endfunction
  // one retire through the partner, then commit and fault checks
  task automatic ret1(input tgf_pkg::tgf_retire_type r,
                      input tgf_pkg::tgf_guard_type g);
    logic [7:0] s;
    logic b, d, p;
    s = sub(r);
    b = g.length_fault | (|g.prot_hit);
    d = |g.det_hit;
    p = mode[5] & pfl & r.is_ret;
    if (p)
      s = 8'h20;
    @(posedge clk);
    go   <= 1'b1;
    cmd  <= r;
    gcmd <= g;
    @(posedge clk);
    go <= 1'b0;
    #1;
    chk(32'({cm, cr}), b ? 32'h0 : 32'h3);
    chk(32'({hr, spf}), 32'({p & te, s[3] & te & ~b & ~d}));
    @(posedge clk);
    #1;
    if (b | d)
    begin
      chk(32'({flt.valid, flt.ftype, flt.subtype}), 32'({1'b1,
        tgf_pkg::FT_PROTECTION, g.length_fault ? tgf_pkg::FS_LENGTH :
        tgf_pkg::FS_BAD_ACCESS}));
      if (!g.length_fault)
        chk(32'({flt.indicator[21:16], flt.indicator[1:0]}),
            32'({g.det_hit, g.prot_hit}));
      pend = (d & ~b & te) ? s : 8'h00;
    end
    else
    begin
      chk(32'(flt.valid), 32'(te && s != 8'h00));
      if (te && s != 8'h00)
      begin
        chk(32'({flt.ftype, flt.subtype}),
            32'({tgf_pkg::FT_TRACE, s}));
        te = 1'b0;
      end
    end
  endtask
  initial
  begin
    #200000;
    err_total++;
    test_done;
  end
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, tgf_pkg::ADDR_PROC_CTRL, '0);
    chk(rd, '0);
    apb(1'b0, 8'h14, '0);
    chk({se, rd[30:0]}, 32'h80000000);
    setm(8'h04, 1'b1);
    ret1(13'h1600, '0);
    ret1(13'h1c00, '0);
    apb(1'b0, tgf_pkg::ADDR_PROC_CTRL, '0);
    chk(rd, '0);
    $display("test branch done");
    setm(8'h02, 1'b1);
    ret1(13'h1000, 9'h100);
    ret1(13'h1000, 9'h0c0);
    ret1(13'h1000, 9'h021);
    @(posedge clk);
    hret <= 1'b1;
    @(posedge clk);
    hret <= 1'b0;
    #1;
    chk(32'({flt.valid, flt.ftype, flt.subtype}),
        32'({1'b1, tgf_pkg::FT_TRACE, pend}));
    te = 1'b0;
    $display("test guard done");
    @(posedge clk);
    pfl <= 1'b1;
    setm(8'h38, 1'b1);
    ret1(13'h1020, '0);
    setm(8'h38, 1'b1);
    ret1(13'h1100, '0);
    @(posedge clk);
    pfl <= 1'b0;
    $display("test prereturn done");
    repeat (40)
    begin
      rs = xs(rs);
      setm(rs[7:0] & 8'hde, rs[8]);
      ret1({1'b1, rs[27:16]}, '0);
    end
    $display("test random done");
    @(posedge clk);
    hfp <= 1'b1;
    ret1(13'h1000, 9'h040);
    repeat (20) @(posedge clk);
    #1;
    chk(32'({lk, flt.valid}), 32'h3);
    apb(1'b0, tgf_pkg::ADDR_FAULT_STATUS, '0);
    chk(rd, 32'({tgf_pkg::FT_PROTECTION, tgf_pkg::FS_BAD_ACCESS}));
    apb(1'b0, tgf_pkg::ADDR_INDICATOR, '0);
    chk(rd, 32'h0000_0001);
    @(posedge clk);
    rst <= 1'b1;
    hfp <= 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(32'(lk), '0);
    $display("test lockup done");
    test_done;
  end
endmodule
`default_nettype wire

// ==== testbench/tgf_chk_sva.sv ====
// checker: concurrent assertions on the fault unit ports
`timescale 1ns/10ps
`default_nettype none
module tgf_chk
(
  // clock and reset
  input wire logic                    CLOCK,
  input wire logic                    RST,
  input wire logic                    CE,
  // pipeline report
  input wire tgf_pkg::tgf_retire_type RETIRE,
  input wire tgf_pkg::tgf_guard_type  GUARD,
  input wire logic                    PRERET_FLAG,
  input wire logic                    HANDLER_RETURN,
  // outputs watched
  input wire logic                    COMMIT_MEM,
  input wire logic                    COMMIT_REG,
  input wire logic                    HOLD_RETURN,
  input wire tgf_pkg::tgf_fault_type  FAULT,
  input wire logic                    LOCKUP
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  // a trace fault being dispatched this cycle
  wire tf = FAULT.valid && FAULT.ftype == tgf_pkg::FT_TRACE;
  chk_len_commit: assert property (
    RETIRE.valid && GUARD.length_fault |-> !COMMIT_MEM && !COMMIT_REG)
    else $error("commit despite length fault");
  chk_prot_commit: assert property (
    RETIRE.valid && |GUARD.prot_hit |-> !COMMIT_MEM && !COMMIT_REG)
    else $error("commit despite protect hit");
  chk_det_commit: assert property (
    RETIRE.valid && !GUARD.length_fault && GUARD.prot_hit == 2'h0
    |-> COMMIT_MEM && COMMIT_REG) else $error("clean retire not committed");
  chk_trace_subtype: assert property (
    tf |-> !FAULT.subtype[0] && FAULT.subtype != 8'h00)
    else $error("bad trace subtype");
  chk_preret_alone: assert property (
    tf && FAULT.subtype[5] |-> FAULT.subtype == 8'h20)
    else $error("prereturn mixed with others");
  chk_lockup_stays: assert property (
    LOCKUP |=> LOCKUP) else $error("lockup left without reset");
  chk_hold_cause: assert property (
    HOLD_RETURN |-> RETIRE.valid && RETIRE.is_ret && PRERET_FLAG)
    else $error("return held without cause");
  chk_branch_cause: assert property (
    tf && FAULT.subtype[2] && $past(CE) |-> $past(HANDLER_RETURN) ||
    $past(RETIRE.valid && RETIRE.is_branch && RETIRE.taken &&
    !RETIRE.is_bal && !RETIRE.is_call)) else $error("stray branch event");
  // main scenarios reached
  cov_trace: cover property (tf);
  cov_hold: cover property (HOLD_RETURN);
  cov_lockup: cover property (LOCKUP);
endmodule
bind tgf_fault_unit tgf_chk chk_i
(
  .CLOCK          (CLOCK),
  .RST            (RST),
  .CE             (CE),
  .RETIRE         (RETIRE),
  .GUARD          (GUARD),
  .PRERET_FLAG    (PRERET_FLAG),
  .HANDLER_RETURN (HANDLER_RETURN),
  .COMMIT_MEM     (COMMIT_MEM),
  .COMMIT_REG     (COMMIT_REG),
  .HOLD_RETURN    (HOLD_RETURN),
  .FAULT          (FAULT),
  .LOCKUP         (LOCKUP)
);
`default_nettype wire

// ==== testbench/tgf_pipe_model.sv ====
// partner: pipeline stage reporting one retiring instruction per request
`timescale 1ns/10ps
`default_nettype none
module tgf_pipe_model
(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // request from the bench
  input  wire logic                    go,
  input  wire tgf_pkg::tgf_retire_type cmd,
  input  wire tgf_pkg::tgf_guard_type  gcmd,
  // report towards the fault unit
  output var tgf_pkg::tgf_retire_type  retire,
  output var tgf_pkg::tgf_guard_type   guard
);
  // one-cycle retire pulse; idle fields toggle so stale values never pass
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      retire <= '0;
      guard  <= '0;
    end
    else if (go)
    begin
      retire <= cmd;
      guard  <= gcmd;
    end
    else
    begin
      retire <= {1'b0, ~retire[11:0]};
      guard  <= ~guard;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/tgf_apb_regs.sv ====
// apb slave holding trace control, process control and status view
`timescale 1ns/10ps
`default_nettype none
module tgf_apb_regs
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // block side
  input  wire logic [31:0] status_word,
  input  wire logic [31:0] indicator_word,
  input  wire logic [31:0] event_count,
  input  wire logic        te_clear,
  output logic      [7:0]  tc_mode,
  output logic             pc_te
);

  logic [7:0]  tc_mode_r;  // trace mode bits
  logic        pc_te_r;    // trace enable
  logic [31:0] prdata_r;
  logic        pslverr_r;
  logic        access;     // access phase
  logic        mapped;

  assign access  = psel && penable;
  assign pready  = 1'b1;   // zero wait states
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r & access;
  assign tc_mode = tc_mode_r;
  assign pc_te   = pc_te_r;

  // address decode
  always_comb
  begin
    unique case (paddr)
      tgf_pkg::ADDR_TRACE_CTRL,
      tgf_pkg::ADDR_PROC_CTRL,
      tgf_pkg::ADDR_FAULT_STATUS,
      tgf_pkg::ADDR_INDICATOR,
      tgf_pkg::ADDR_EVENT_COUNT: mapped = 1'b1;
      default:                   mapped = 1'b0;
    endcase
  end

  // trace control register write
  always_ff @(posedge clk)
  begin
    if (rst)
      tc_mode_r <= tgf_pkg::TC_MODE_RESET;
    else if (ce && access && pwrite && paddr == tgf_pkg::ADDR_TRACE_CTRL)
      tc_mode_r <= pwdata[7:0];
  end

  // trace enable; hardware clears it when entering the trace handler
  always_ff @(posedge clk)
  begin
    if (rst)
      pc_te_r <= tgf_pkg::PC_TE_RESET;
    else if (ce && te_clear)
      pc_te_r <= 1'b0;
    else if (ce && access && pwrite && paddr == tgf_pkg::ADDR_PROC_CTRL)
      pc_te_r <= pwdata[tgf_pkg::PC_TE_BIT];
  end

  // read data, registered in the setup cycle so it is valid in access
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else if (ce && psel && !penable)
    begin
      pslverr_r <= !mapped;
      unique case (paddr)
        tgf_pkg::ADDR_TRACE_CTRL:   prdata_r <= {24'h00_0000, tc_mode_r};
        tgf_pkg::ADDR_PROC_CTRL:    prdata_r <= {31'h0000_0000, pc_te_r};
        tgf_pkg::ADDR_FAULT_STATUS: prdata_r <= status_word;
        tgf_pkg::ADDR_INDICATOR:    prdata_r <= indicator_word;
        tgf_pkg::ADDR_EVENT_COUNT:  prdata_r <= event_count;
        default:                    prdata_r <= 32'h0000_0000;
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== verilog/tgf_fault_unit.sv ====
// trace and guarded-memory fault generation unit
// --------------------------------------------------------------------------
// Overview of operation
// - length fault suppresses the instruction's effects
// - protect violation blocks memory and register writes
// - detect violation completes instruction before faulting
// - length or protect fault drops pending trace
// - detect fault keeps trace, reported after return
// - indicator bits 1:0 protect, 21:16 detect
// - prefetch may fault 16 words below region
// - fetch-protected handler loops until reset only
// - one fault reports all events of instruction
// - mode bit detects, trace enable raises fault
// - fault after instruction, prereturn before return
// - instruction mode traces every completed instruction
// - branch mode only taken plain branches
// - call mode: call, branch-and-link, fault call
// - return mode traces each completed return
// - prereturn needs frame flag, set by call trace
// - prereturn trace fault always reported alone
// - supervisor mode: calls supervisor, return status 2/3
// - mark mode: mark, fmark and breakpoint matches
// --------------------------------------------------------------------------
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module tgf_fault_unit
(
  // clock, reset, enable
  input  wire logic                    CLOCK,
  input  wire logic                    RST,
  input  wire logic                    CE,
  // apb register bus
  input  wire logic                    PSEL,
  input  wire logic                    PENABLE,
  input  wire logic                    PWRITE,
  input  wire logic [7:0]              PADDR,
  input  wire logic [31:0]             PWDATA,
  output logic      [31:0]             PRDATA,
  output logic                         PREADY,
  output logic                         PSLVERR,
  // pipeline report
  input  wire tgf_pkg::tgf_retire_type RETIRE,
  input  wire tgf_pkg::tgf_guard_type  GUARD,
  input  wire logic                    PRERET_FLAG,
  input  wire logic                    HANDLER_RETURN,
  input  wire logic                    HANDLER_FETCH_PROT,
  // commit gating back to the pipeline
  output logic                         COMMIT_MEM,
  output logic                         COMMIT_REG,
  output logic                         SET_PRERET_FLAG,
  output logic                         HOLD_RETURN,
  // fault dispatch
  output tgf_pkg::tgf_fault_type       FAULT,
  output logic                         LOCKUP
);

  // ------------------------------------------------------------------------
  // state machine and storage
  // ------------------------------------------------------------------------
  typedef enum logic [1:0]
  {
    ST_RUN    = 2'b00,  // normal execution
    ST_DEFER  = 2'b01,  // trace held across a detect fault handler
    ST_LOCK   = 2'b10   // handler fetch-protected, wait for reset
  } tgf_state_type;

  tgf_state_type state_r;         // current state
  tgf_state_type state_nxt;
  logic [7:0]    deferred_r;      // trace subtype held across handler
  tgf_pkg::tgf_fault_type fault_r; // registered fault output
  tgf_pkg::tgf_fault_type fault_nxt;
  logic [31:0]   count_r;         // faults raised, for software
  logic [7:0]    tc_mode;         // trace mode bits
  logic          pc_te;           // trace enable
  logic          te_clear;        // disable tracing on trace fault
  logic [7:0]    events;          // post-instruction trace events
  logic          preret_event;    // before-return event this cycle
  logic          prot_any;
  logic          det_any;
  logic          kill;            // instruction suppressed

  // ------------------------------------------------------------------------
  // helper functions
  // ------------------------------------------------------------------------
  // indicator word from protect and detect pair hits
  function automatic logic [31:0] ind_word(input logic [1:0] p,
                                           input logic [5:0] d);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[tgf_pkg::IND_PROT_LSB +: 2] = p;
    w[tgf_pkg::IND_DET_LSB +: 6]  = d;
    return w;
  endfunction

  // gate an event by its mode bit
  function automatic logic gate(input logic [7:0] mode, input int bitpos,
                                input logic cond);
    return mode[bitpos] && cond;
  endfunction

  // ------------------------------------------------------------------------
  // register file
  // ------------------------------------------------------------------------
  tgf_apb_regs u_regs
  (
    .clk            (CLOCK),
    .rst            (RST),
    .ce             (CE),
    .psel           (PSEL),
    .penable        (PENABLE),
    .pwrite         (PWRITE),
    .paddr          (PADDR),
    .pwdata         (PWDATA),
    .prdata         (PRDATA),
    .pready         (PREADY),
    .pslverr        (PSLVERR),
    .status_word    ({20'h0_0000, fault_r.ftype, fault_r.subtype}),
    .indicator_word (fault_r.indicator),
    .event_count    (count_r),
    .te_clear       (te_clear),
    .tc_mode        (tc_mode),
    .pc_te          (pc_te)
  );

  // ------------------------------------------------------------------------
  // event detection
  // ------------------------------------------------------------------------
  assign prot_any = |GUARD.prot_hit;
  assign det_any  = |GUARD.det_hit;
  // length or protect fault: no effect at all; prefetch hits below a
  // fetch-protected region arrive here as ordinary protect hits
  assign kill     = GUARD.length_fault || prot_any;

  // memory and register commit; detect lets the instruction finish
  assign COMMIT_MEM = RETIRE.valid && !kill;
  assign COMMIT_REG = RETIRE.valid && !kill;

  // detection of post-instruction events, one bit per subtype
  always_comb
  begin
    events = 8'h00;                                      // bit 0 reserved
    events[tgf_pkg::SB_INSTR]  = gate(tc_mode, tgf_pkg::SB_INSTR, 1'b1);
    events[tgf_pkg::SB_BRANCH] = gate(tc_mode, tgf_pkg::SB_BRANCH,
                                      RETIRE.is_branch && RETIRE.taken &&
                                      !RETIRE.is_bal && !RETIRE.is_call);
    events[tgf_pkg::SB_CALL]   = gate(tc_mode, tgf_pkg::SB_CALL,
                                      RETIRE.is_call || RETIRE.is_bal ||
                                      RETIRE.fault_call);
    events[tgf_pkg::SB_RETURN] = gate(tc_mode, tgf_pkg::SB_RETURN,
                                      RETIRE.is_ret);
    events[tgf_pkg::SB_SUPER]  = gate(tc_mode, tgf_pkg::SB_SUPER,
                                      RETIRE.is_calls_sup ||
                                      (RETIRE.is_ret &&
                                       (RETIRE.ret_status ==
                                        tgf_pkg::RS_SUPER_A ||
                                        RETIRE.ret_status ==
                                        tgf_pkg::RS_SUPER_B)));
    events[tgf_pkg::SB_MARK]   = gate(tc_mode, tgf_pkg::SB_MARK,
                                      RETIRE.is_mark ||
                                      RETIRE.bkpt_hit);
    if (!RETIRE.valid)
      events = 8'h00;
  end

  // prereturn is seen before the return executes, only with the flag
  assign preret_event = RETIRE.valid && RETIRE.is_ret && PRERET_FLAG &&
                        tc_mode[tgf_pkg::SB_PRERET];

  // the return waits while its prereturn fault is taken
  assign HOLD_RETURN = preret_event && pc_te && state_r == ST_RUN;

  // servicing a call trace marks the new frame for prereturn
  assign SET_PRERET_FLAG = pc_te && !kill && state_r == ST_RUN &&
                           events[tgf_pkg::SB_CALL];

  // ------------------------------------------------------------------------
  // fault selection
  // ------------------------------------------------------------------------
  // priority: lockup, guard faults, prereturn alone, then trace
  always_comb
  begin
    state_nxt = state_r;
    fault_nxt = '0;
    te_clear  = 1'b0;
    unique case (state_r)
      ST_RUN:
      begin
        if (RETIRE.valid && kill)
        begin
          // trace event of this instruction is dropped
          fault_nxt.valid   = 1'b1;
          fault_nxt.ftype   = tgf_pkg::FT_PROTECTION;
          fault_nxt.subtype = GUARD.length_fault ? tgf_pkg::FS_LENGTH
                                                 : tgf_pkg::FS_BAD_ACCESS;
          fault_nxt.indicator = ind_word(GUARD.prot_hit, GUARD.det_hit);
          if (HANDLER_FETCH_PROT)
            state_nxt = ST_LOCK;
        end
        else if (RETIRE.valid && det_any)
        begin
          // instruction completed; hold its trace for after the handler
          fault_nxt.valid     = 1'b1;
          fault_nxt.ftype     = tgf_pkg::FT_PROTECTION;
          fault_nxt.subtype   = tgf_pkg::FS_BAD_ACCESS;
          fault_nxt.indicator = ind_word(2'b00, GUARD.det_hit);
          state_nxt = HANDLER_FETCH_PROT ? ST_LOCK : ST_DEFER;
        end
        else if (HOLD_RETURN)
        begin
          // prereturn never shares a fault with other subtypes
          fault_nxt.valid   = 1'b1;
          fault_nxt.ftype   = tgf_pkg::FT_TRACE;
          fault_nxt.subtype = 8'h00;
          fault_nxt.subtype[tgf_pkg::SB_PRERET] = 1'b1;
          te_clear = 1'b1;
        end
        else if (pc_te && |events)
        begin
          // all events of one instruction in a single fault
          fault_nxt.valid   = 1'b1;
          fault_nxt.ftype   = tgf_pkg::FT_TRACE;
          fault_nxt.subtype = events;
          te_clear = 1'b1;
        end
        // with trace disabled only guard faults are raised and the pipeline runs
      end
      ST_DEFER:
      begin
        if (HANDLER_RETURN)
        begin
          state_nxt = ST_RUN;
          if (pc_te && |deferred_r)
          begin
            fault_nxt.valid   = 1'b1;
            fault_nxt.ftype   = tgf_pkg::FT_TRACE;
            fault_nxt.subtype = deferred_r;
            te_clear = 1'b1;
          end
        end
      end
      ST_LOCK:
      begin
        // handler fetch faults again forever; only reset leaves
        fault_nxt.valid   = 1'b1;
        fault_nxt.ftype   = tgf_pkg::FT_PROTECTION;
        fault_nxt.subtype = tgf_pkg::FS_BAD_ACCESS;
        fault_nxt.indicator = fault_r.indicator;
      end
      default:
        state_nxt = ST_LOCK;
    endcase
  end

  // ------------------------------------------------------------------------
  // state registers
  // ------------------------------------------------------------------------
  // state transition
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      state_r <= ST_RUN;
    else if (CE)
      state_r <= state_nxt;
  end

  // deferred trace capture on a detect fault
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      deferred_r <= 8'h00;
    else if (CE && state_r == ST_RUN && RETIRE.valid && !kill && det_any)
      deferred_r <= events;
    else if (CE && state_r == ST_DEFER && HANDLER_RETURN)
      deferred_r <= 8'h00;
  end

  // fault output register; last fault held in fields for software
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      fault_r <= '0;
    else if (CE)
    begin
      fault_r.valid <= fault_nxt.valid;
      if (fault_nxt.valid)
      begin
        fault_r.ftype     <= fault_nxt.ftype;
        fault_r.subtype   <= fault_nxt.subtype;
        fault_r.indicator <= fault_nxt.indicator;
      end
    end
  end

  // fault counter, wraps
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      count_r <= 32'h0000_0000;
    else if (CE && fault_nxt.valid)
      count_r <= count_r + 32'h0000_0001;
  end

  assign FAULT  = fault_r;
  assign LOCKUP = (state_r == ST_LOCK);

endmodule
`default_nettype wire
